/* src/prfa_regfile.v */
// Paged register file address decoder with working pointers
`timescale 1ns/1ps
`default_nettype none
`include "prfa_map.vh"
module prfa_regfile #(
   parameter PAGE_W = 6
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Register access request from the core
   input wire acc_valid,
   input wire acc_write,
   input wire acc_working,
   input wire [7:0] acc_addr,
   input wire [3:0] acc_index,
   input wire acc_double,
   input wire acc_bitop,
   input wire [2:0] acc_bit,
   input wire [15:0] acc_wdata,
   // Answer to the core
   output reg acc_ack,
   output reg acc_error,
   output reg [15:0] acc_rdata,
   // Pointer operations from the core
   input wire ptr_op_valid,
   input wire [1:0] ptr_op,
   input wire [5:0] ptr_op_arg,
   // Pointer state
   output reg [4:0] low_block_pointer,
   output reg [4:0] high_block_pointer,
   output reg split_mode,
   output reg [PAGE_W-1:0] peripheral_page_pointer,
   // Peripheral bank port, word wide with bit masks
   output wire per_valid,
   output wire per_write,
   output wire [PAGE_W-1:0] per_page,
   output wire [2:0] per_word,
   output wire [15:0] per_wmask,
   output wire [15:0] per_wdata,
   input wire [15:0] per_rdata
);
   // Request decode
   reg [7:0] byte_addr;
   reg refuse;
   reg [15:0] mask;
   reg [15:0] data;
   reg [1:0] src;

   // Pointer registers as seen through ordinary register addressing
   reg [15:0] ptr_word;
   reg [15:0] page_word;
   reg [15:0] next_ptr_word;
   reg [15:0] next_page_word;

   // Qualified strobes and storage read data
   wire take;
   wire wr_ok;
   wire mem_we;
   wire ptr_we;
   wire page_we;
   wire [15:0] mem_q;

   // First answer stage
   reg s1_valid;
   reg s1_err;
   reg [1:0] s1_src;
   reg s1_double;
   reg s1_odd;
   reg [15:0] s1_snap;

   // Answer word picked from the noted source
   reg [15:0] word;

   // Working index to full address; split mode uses two 8-register blocks
   always @*
   begin
      if (acc_working)
      begin
         if (!split_mode)
            byte_addr = {low_block_pointer[4:1], acc_index};
         else if (!acc_index[3])
            byte_addr = {low_block_pointer, acc_index[2:0]};
         else
            byte_addr = {high_block_pointer, acc_index[2:0]};
      end
      else
      begin
         // Direct addresses pass unchanged; refusal is decided apart
         byte_addr = acc_addr;
      end
   end

   // Refusal: direct into the hidden group, odd pair, direct or paired bit operation
   always @*
   begin
      refuse = 1'b0;
      // A refused access is still answered, so the core never stalls
      if (!acc_working && acc_addr[7:4] == `PRFA_GROUP_NODIRECT)
         refuse = 1'b1;
      if (acc_double && byte_addr[0])
         refuse = 1'b1;
      // Bit operations need the short index form and a single byte
      if (acc_bitop && (!acc_working || acc_double))
         refuse = 1'b1;
   end

   // Lane and mask: even byte sits in the high lane, odd byte in the low lane
   always @*
   begin
      if (acc_double)
      begin
         // Pair access: even byte in the high lane, odd byte in the low
         mask = 16'hffff;
         data = acc_wdata;
      end
      else if (acc_bitop)
      begin
         // One bit through the mask; the rest of the byte is kept
         mask = byte_addr[0] ? {8'h00, 8'h01 << acc_bit} :
                {8'h01 << acc_bit, 8'h00};
         data = {16{acc_wdata[0]}};
      end
      else
      begin
         mask = byte_addr[0] ? 16'h00ff : 16'hff00;
         data = {acc_wdata[7:0], acc_wdata[7:0]};
      end
   end

   // Source decode: peripheral window, pointer words, or plain storage
   always @*
   begin
      // Window first: pointer words sit in group 14, never in 15
      if (byte_addr[7:4] == `PRFA_GROUP_PER)
         src = `PRFA_SRC_PER;
      else if (byte_addr[7:1] == `PRFA_WORD_PTR_PAIR)
         src = `PRFA_SRC_PTR;
      else if (byte_addr[7:1] == `PRFA_WORD_PAGE)
         src = `PRFA_SRC_PAGE;
      else
         src = `PRFA_SRC_MEM;
   end

   // Only taken writes may touch state; a refused access changes nothing
   assign take = acc_valid & ~refuse;
   assign wr_ok = take & acc_write;
   assign mem_we = wr_ok && src == `PRFA_SRC_MEM;
   assign ptr_we = wr_ok && src == `PRFA_SRC_PTR;
   assign page_we = wr_ok && src == `PRFA_SRC_PAGE;

   // Pointer pair as seen on the bus: block in the top five bits
   always @*
   begin
      // Spare bits read as zero and ignore writes
      ptr_word = {low_block_pointer, 2'b00, split_mode,
                  high_block_pointer, 3'b000};
      page_word = {{(8-PAGE_W){1'b0}}, peripheral_page_pointer, 8'h00};
      next_ptr_word = (ptr_word & ~mask) | (data & mask);
      next_page_word = (page_word & ~mask) | (data & mask);
   end

   // Pointer registers; a pointer operation beats a same-cycle write
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Reset values are a choice; software sets pointers before use
         low_block_pointer <= `PRFA_RST_BLOCK;
         high_block_pointer <= `PRFA_RST_BLOCK;
         split_mode <= `PRFA_RST_SPLIT;
         peripheral_page_pointer <= `PRFA_RST_PAGE;
      end
      else if (ptr_op_valid)
      begin
         case (ptr_op)
            `PRFA_OP_GROUP:
            begin
               // Whole group: both blocks of group arg/2, no split
               // Odd and even arguments land in the same group
               low_block_pointer <= ptr_op_arg[4:0];
               high_block_pointer <= {ptr_op_arg[4:1], 1'b1};
               split_mode <= 1'b0;
            end
            `PRFA_OP_LOW:
            begin
               // Choosing one block alone implies split addressing
               low_block_pointer <= ptr_op_arg[4:0];
               split_mode <= 1'b1;
            end
            `PRFA_OP_HIGH:
            begin
               high_block_pointer <= ptr_op_arg[4:0];
               split_mode <= 1'b1;
            end
            `PRFA_OP_PAGE:
            begin
               // Page pointer only steers the window, never the blocks
               peripheral_page_pointer <= ptr_op_arg[PAGE_W-1:0];
            end
            default:
               split_mode <= split_mode;
         endcase
      end
      else if (ptr_we)
      begin
         // Written on the edge, steering the very next access
         low_block_pointer <= next_ptr_word[15:11];
         split_mode <= next_ptr_word[8];
         high_block_pointer <= next_ptr_word[7:3];
      end
      else if (page_we)
      begin
         peripheral_page_pointer <= next_page_word[8+PAGE_W-1:8];
      end
   end

   // Peripheral strobes are combinational so the bank sees the request
   // in the request cycle; the page pointer picks the pack
   assign per_valid = take && src == `PRFA_SRC_PER;
   assign per_write = per_valid & acc_write;
   assign per_page = peripheral_page_pointer;
   assign per_word = byte_addr[3:1];
   // Bank lanes follow the storage layout, even byte in the high lane
   assign per_wmask = mask;
   assign per_wdata = data;

   // General storage, 128 words of two bytes; group 15 words go unused
   // Write enable excludes the window and the pointer words
   prfa_store #(
      .AW(7),
      .DW(16)
   ) u_store (
      .clk(clk),
      .rst_n(rst_n),
      .addr(byte_addr[7:1]),
      .we(mem_we),
      .wmask(mask),
      .wdata(data),
      .rdata(mem_q)
   );

   // First answer stage: note source and lane while storage reads
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_valid <= 1'b0;
         s1_err <= 1'b0;
         s1_src <= `PRFA_SRC_MEM;
         s1_double <= 1'b0;
         s1_odd <= 1'b0;
         s1_snap <= 16'h0000;
      end
      else
      begin
         s1_valid <= acc_valid;
         s1_err <= acc_valid & refuse;
         s1_src <= src;
         s1_double <= acc_double;
         s1_odd <= byte_addr[0];
         // Snapshot before the edge, so a pointer write returns old content
         s1_snap <= (src == `PRFA_SRC_PAGE) ? page_word : ptr_word;
      end
   end

   // Peripheral data are expected one cycle after the strobe
   // A slow bank would need a ready input here; none is provided
   always @*
   begin
      case (s1_src)
         `PRFA_SRC_MEM: word = mem_q;
         `PRFA_SRC_PER: word = per_rdata;
         default: word = s1_snap;
      endcase
   end

   // Second stage: byte extraction into the answer register
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_ack <= 1'b0;
         acc_error <= 1'b0;
         acc_rdata <= 16'h0000;
      end
      else
      begin
         acc_ack <= s1_valid;
         acc_error <= s1_err;
         // Read data stand until the next answer
         if (!s1_valid)
            acc_rdata <= acc_rdata;
         else if (s1_err)
            acc_rdata <= 16'h0000;
         else if (s1_double)
            acc_rdata <= word;
         else if (s1_odd)
            acc_rdata <= {8'h00, word[7:0]};
         else
            acc_rdata <= {8'h00, word[15:8]};
      end
   end
endmodule
`default_nettype wire

/* src/prfa_map.vh */
// Address map and constants for the paged register file decoder
`ifndef PRFA_MAP_VH
`define PRFA_MAP_VH
// Group numbers
`define PRFA_GROUP_NODIRECT 4'hd
`define PRFA_GROUP_SYS 4'he
`define PRFA_GROUP_PER 4'hf
// Pointer registers in the system group, as 16-bit word indices
`define PRFA_WORD_PTR_PAIR 7'h74
`define PRFA_WORD_PAGE 7'h75
// Pointer operation codes
`define PRFA_OP_GROUP 2'h0
`define PRFA_OP_LOW 2'h1
`define PRFA_OP_HIGH 2'h2
`define PRFA_OP_PAGE 2'h3
// Read source selects
`define PRFA_SRC_MEM 2'h0
`define PRFA_SRC_PER 2'h1
`define PRFA_SRC_PTR 2'h2
`define PRFA_SRC_PAGE 2'h3
// Reset values of the pointers
`define PRFA_RST_BLOCK 5'h00
`define PRFA_RST_PAGE 6'h00
`define PRFA_RST_SPLIT 1'b0
`endif

/* src/prfa_store.v */
// Bit-masked storage array with registered read data
`timescale 1ns/1ps
`default_nettype none
module prfa_store #(
   parameter AW = 7,
   parameter DW = 16
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Access port
   input wire [AW-1:0] addr,
   input wire we,
   input wire [DW-1:0] wmask,
   input wire [DW-1:0] wdata,
   output reg [DW-1:0] rdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // Masked write keeps untouched bits, so bit operations need no read first
   always @(posedge clk)
   begin
      if (we)
         mem[addr] <= (mem[addr] & ~wmask) | (wdata & wmask);
   end

   // Read port returns the old word when read and write coincide
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= {DW{1'b0}};
      else
         rdata <= mem[addr];
   end
endmodule
`default_nettype wire

/* verification/prfa_per_model.sv */
// Peripheral register pack model behind the group 15 window
`timescale 1ns/1ps
`default_nettype none
module prfa_per_model (
   // Clock
   input wire logic clk,
   // Bank port
   input wire logic per_valid,
   input wire logic per_write,
   input wire logic [5:0] per_page,
   input wire logic [2:0] per_word,
   input wire logic [15:0] per_wmask,
   input wire logic [15:0] per_wdata,
   output logic [15:0] per_rdata
);
   logic [15:0] mem [0:511];
   wire [8:0] w = {per_page, per_word};
   initial for (int i = 0; i < 512; i++) mem[i] = 16'h0000;
   initial per_rdata = 16'h0000;
   // Old content out next cycle; idle cycles toggle so stale data never hits
   always @(posedge clk)
      if (per_valid)
      begin
         per_rdata <= mem[w];
         if (per_write)
            mem[w] <= (mem[w] & ~per_wmask) | (per_wdata & per_wmask);
      end
      else
         per_rdata <= ~per_rdata;
endmodule
`default_nettype wire

/* verification/prfa_regfile_sva.sv */
// Port-level assertions for the paged register file decoder
`timescale 1ns/1ps
`default_nettype none
module prfa_regfile_sva #(
   parameter PAGE_W = 6
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Access side
   input wire logic acc_valid,
   input wire logic acc_working,
   input wire logic [7:0] acc_addr,
   input wire logic acc_double,
   input wire logic acc_bitop,
   input wire logic acc_ack,
   input wire logic acc_error,
   // Pointer side
   input wire logic ptr_op_valid,
   input wire logic [1:0] ptr_op,
   input wire logic [5:0] ptr_op_arg,
   input wire logic [4:0] low_block_pointer,
   input wire logic [4:0] high_block_pointer,
   input wire logic split_mode,
   input wire logic [PAGE_W-1:0] peripheral_page_pointer,
   // Peripheral side
   input wire logic per_valid,
   input wire logic [2:0] per_word
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire dir = acc_valid && !acc_working;
   AST_ACK_LAT: assert property (acc_valid |-> ##2 acc_ack)
      else $error("answer missing two cycles after request");
   AST_D13: assert property (dir && acc_addr[7:4] == 4'hd |-> ##2 acc_error)
      else $error("direct group 13 access not refused");
   AST_ODD: assert property (dir && acc_double && acc_addr[0] |-> ##2 acc_error)
      else $error("odd double access not refused");
   AST_BIT: assert property (dir && acc_bitop |-> ##2 acc_error)
      else $error("direct bit operation not refused");
   AST_GRP: assert property (ptr_op_valid && ptr_op == 2'h0 |=>
      low_block_pointer == $past(ptr_op_arg[4:0]) && !split_mode &&
      high_block_pointer == {$past(ptr_op_arg[4:1]), 1'b1})
      else $error("group select gave wrong pointers");
   AST_LOW: assert property (ptr_op_valid && ptr_op == 2'h1 |=> split_mode
      && low_block_pointer == $past(ptr_op_arg[4:0]))
      else $error("low block select gave wrong pointer");
   AST_PAGE: assert property (ptr_op_valid && ptr_op == 2'h3 |=>
      peripheral_page_pointer == $past(ptr_op_arg[PAGE_W-1:0]))
      else $error("page select gave wrong page");
   AST_PER: assert property (dir && acc_addr[7:4] == 4'hf && !acc_bitop
      && !acc_double |-> per_valid && per_word == acc_addr[3:1])
      else $error("group 15 access not sent to peripheral");
   CV_HIGH: cover property (ptr_op_valid && ptr_op == 2'h2);
   CV_ERR: cover property (acc_error);
   CV_PER: cover property (per_valid);
endmodule
`default_nettype wire

/* verification/prfa_regfile_bench.sv */
// Self-checking bench for the paged register file decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
   $display("wrong value at %0t: %h %h", $time, a, b); end end
module prfa_regfile_bench;
   logic clk = 0, rst_n = 0, av = 0, aw = 0, wk = 0, dbl = 0, bop = 0, pv = 0;
   logic [7:0] ad = 0;
   logic [3:0] ix = 0;
   logic [2:0] bn = 0;
   logic [15:0] wd = 0;
   logic [1:0] op = 0;
   logic [5:0] arg = 0;
   logic [31:0] lf = 32'h7d6a8fc4;
   wire ack, err, sm, qv, qw;
   wire [15:0] rd, qm, qd, qr;
   wire [4:0] lo, hi;
   wire [5:0] pg, qp;
   wire [2:0] qn;
   // Model bytes start unknown, as the design's storage does
   logic [7:0] mem [256];
   int pm [1024], mlo, mhi, msp, mpg, err_count, checks_done;
   prfa_regfile #(.PAGE_W(6)) dut_u (.clk(clk), .rst_n(rst_n),
      .acc_valid(av), .acc_write(aw), .acc_working(wk), .acc_addr(ad),
      .acc_index(ix), .acc_double(dbl), .acc_bitop(bop), .acc_bit(bn),
      .acc_wdata(wd), .acc_ack(ack), .acc_error(err), .acc_rdata(rd),
      .ptr_op_valid(pv), .ptr_op(op), .ptr_op_arg(arg),
      .low_block_pointer(lo), .high_block_pointer(hi), .split_mode(sm),
      .peripheral_page_pointer(pg), .per_valid(qv), .per_write(qw),
      .per_page(qp), .per_word(qn), .per_wmask(qm), .per_wdata(qd),
      .per_rdata(qr));
   prfa_per_model per_u (.clk(clk), .per_valid(qv), .per_write(qw),
      .per_page(qp), .per_word(qn), .per_wmask(qm), .per_wdata(qd),
      .per_rdata(qr));
   always #4 clk = ~clk;
   function logic [31:0] nx(logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
   endfunction
   // Working index to absolute address
   function int ea(int i);
      if (!msp)
         return mlo / 2 * 16 + i;
      return i < 8 ? mlo * 8 + i : mhi * 8 + i - 8;
   endfunction
   // Model byte read: window, pointer words, plain storage
   function logic [7:0] rb(int a);
      if (a >= 240)
         return 8'(pm[mpg * 16 + a - 240]);
      case (a)
         232: return 8'(mlo * 8 + msp);
         233: return 8'(mhi * 8);
         234: return 8'(mpg);
         235: return 8'h00;
         default: return mem[a];
      endcase
   endfunction
   task wb(int a, int v);
      if (a >= 240)
         pm[mpg * 16 + a - 240] = v;
      else if (a == 232)
         {mlo, msp} = {v / 8, v % 2};
      else if (a == 233)
         mhi = v / 8;
      else if (a == 234)
         mpg = v % 64;
      else if (a != 235)
         mem[a] = 8'(v);
   endtask
   task stop_test;
      if (err_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // One access, answer checked against the model
   task acc(int w, int k, int a, int i, int d, int b, int n, int v);
      int e, x, bad;
      logic [15:0] ex;
      e = k ? ea(i) : a;
      bad = (!k && a / 16 == 13) || (d && e % 2) || (b && (!k || d));
      ex = bad ? 16'h0000 : 16'(d ? rb(e) * 256 + rb(e + 1) : rb(e));
      if (!bad && w && b)
         wb(e, (rb(e) & ~(1 << n)) | (v % 2 << n));
      else if (!bad && w && d)
      begin
         wb(e, v / 256 % 256);
         wb(e + 1, v % 256);
      end
      @(negedge clk);
      {av, aw, wk, ad, ix} = {1'b1, 1'(w), 1'(k), 8'(a), 4'(i)};
      {dbl, bop, bn, wd} = {1'(d), 1'(b), 3'(n), 16'(v)};
      @(negedge clk);
      av = 0;
      for (x = 0; ack !== 1'b1 && x < 4; x++)
         @(negedge clk);
      if (x == 4)
      begin
         err_count++;
         stop_test;
      end
      `CHK(err, 1'(bad))
      `CHK(rd, ex)
      if (!bad && w && !b && !d)
         wb(e, v % 256);
   endtask
   task pop(int o, int g);
      @(negedge clk);
      {pv, op, arg} = {1'b1, 2'(o), 6'(g)};
      @(negedge clk);
      pv = 0;
      case (o)
         0:
         begin
            mlo = g % 32;
            mhi = g % 32 | 1;
            msp = 0;
         end
         1:
         begin
            mlo = g;
            msp = 1;
         end
         2:
         begin
            mhi = g;
            msp = 1;
         end
         default: mpg = g;
      endcase
      `CHK({lo, hi, sm, pg}, {5'(mlo), 5'(mhi), 1'(msp), 6'(mpg)})
   endtask
   initial
   begin
      {mlo, mhi, msp, mpg, err_count, checks_done} = 0;
      for (int j = 0; j < 1024; j++)
         pm[j] = 0;
      repeat (5) @(negedge clk);
      rst_n = 1;
      for (int a = 0; a < 256; a++)
         if (a / 16 != 13 && (a < 232 || a > 235))
            acc(1, 0, a, 0, 0, 0, 0, a * 7 % 256);
      pop(0, 27);
      for (int i = 0; i < 16; i++)
         acc(1, 1, 0, i, 0, 0, 0, i + 90);
      pop(0, 2);
      acc(0, 1, 0, 3, 0, 0, 0, 0);
      acc(0, 0, 19, 0, 0, 0, 0, 0);
      pop(1, 2);
      pop(2, 27);
      acc(0, 1, 0, 15, 0, 0, 0, 0);
      acc(0, 0, 232, 0, 1, 0, 0, 0);
      acc(1, 0, 233, 0, 0, 0, 0, 56);
      `CHK(hi, 5'h07)
      acc(1, 0, 17, 0, 1, 0, 0, 1);
      acc(1, 0, 16, 0, 0, 1, 3, 1);
      pop(0, 28);
      acc(1, 1, 0, 4, 0, 1, 2, 1);
      acc(0, 1, 0, 4, 0, 0, 0, 0);
      pop(3, 37);
      acc(1, 0, 244, 0, 0, 0, 0, 165);
      acc(0, 0, 244, 0, 0, 0, 0, 0);
      pop(3, 0);
      acc(0, 0, 244, 0, 0, 0, 0, 0);
      for (int t = 0; t < 600; t++)
      begin
         lf = nx(lf);
         if (lf[3:0] == 0)
            pop(lf[5:4], lf[5:4] == 3 ? lf[13:8] : lf[12:8]);
         else
            acc(lf[4], lf[5], lf[15:8], lf[19:16], lf[6] & lf[7],
               lf[20] & lf[21], lf[24:22], lf[31:16]);
      end
      stop_test;
   end
endmodule
bind prfa_regfile prfa_regfile_sva #(.PAGE_W(PAGE_W)) chk_u (.clk(clk),
   .rst_n(rst_n), .acc_valid(acc_valid), .acc_working(acc_working),
   .acc_addr(acc_addr), .acc_double(acc_double), .acc_bitop(acc_bitop),
   .acc_ack(acc_ack), .acc_error(acc_error), .ptr_op_valid(ptr_op_valid),
   .ptr_op(ptr_op), .ptr_op_arg(ptr_op_arg),
   .low_block_pointer(low_block_pointer),
   .high_block_pointer(high_block_pointer), .split_mode(split_mode),
   .peripheral_page_pointer(peripheral_page_pointer),
   .per_valid(per_valid), .per_word(per_word));
`default_nettype wire
